/* sleep_entry.sv */
// Target-side sleep entry and wake recovery for a two-wire memory.
// Assumes an external controller; the sleep sequence earlier bytes are
// reported by the surrounding target logic through sleepArmed.
module sleep_entry
  import sleep_entry_pkg::*;
#(
  parameter int WAKE_CYCLES_P = WAKE_CYCLES
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sleepArmed,
  input wire logic wakeReq,
  output logic asleep,
  output logic ready,
  output logic stopSeen,
  output logic startSeen
);
  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  logic scl;
  logic sda;
  logic sclPrev_reg;
  logic sdaPrev_reg;

  pin_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sclSync(scl),
    .sdaSync(sda)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end
    else
    begin
      sclPrev_reg <= scl;
      sdaPrev_reg <= sda;
    end
  end

  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  assign sclRise = scl && !sclPrev_reg;
  assign sclFall = !scl && sclPrev_reg;
  assign startDet = scl && sclPrev_reg && sdaPrev_reg && !sda;
  assign stopDet = scl && sclPrev_reg && !sdaPrev_reg && sda;

  // ------------------------------------------------------------
  // Byte framing
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_ACK   = 4'b0100,
    ST_SLEEP = 4'b1000
  } state_e;

  state_e state_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [$clog2(WAKE_CYCLES_P+1)-1:0] wakeCnt_reg;
  logic waking_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      sdaOe <= 1'b0;
    end
    else if (state_reg == ST_SLEEP)
    begin
      sdaOe <= 1'b0;
      if (wakeReq)
        state_reg <= ST_IDLE;
    end
    else if (startDet)
    begin
      state_reg <= ST_SHIFT;
      bitCnt_reg <= 4'h0;
      sdaOe <= 1'b0;
    end
    else if (stopDet)
    begin
      state_reg <= ST_IDLE;
      sdaOe <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
          sdaOe <= 1'b0;
        ST_SHIFT:
        begin
          if (sclRise)
          begin
            shift_reg <= {shift_reg[6:0], sda};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          if (sclFall && bitCnt_reg == 4'h8)
          begin
            if (sleepArmed && shift_reg == SLEEP_FINAL_ADDR)
            begin
              sdaOe <= 1'b1;
              state_reg <= ST_ACK;
            end
            else
              state_reg <= ST_IDLE;
          end
        end
        ST_ACK:
          if (sclRise)
          begin
            // Ninth rising edge: hand over to sleep; release follows at once,
            // which is why the line may rise with the clock high
            state_reg <= ST_SLEEP;
            sdaOe <= 1'b0;
          end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  assign sdaOut = 1'b0;
  assign asleep = (state_reg == ST_SLEEP);

  // ------------------------------------------------------------
  // Wake recovery
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      waking_reg <= 1'b0;
      wakeCnt_reg <= '0;
    end
    else if (state_reg == ST_SLEEP && wakeReq)
    begin
      waking_reg <= 1'b1;
      wakeCnt_reg <= '0;
    end
    else if (waking_reg)
    begin
      // Ending one count early brings ready back exactly WAKE_CYCLES_P cycles after the request, right on the limit
      if (wakeCnt_reg == ($bits(wakeCnt_reg))'(WAKE_CYCLES_P - 1))
        waking_reg <= 1'b0;
      else
        wakeCnt_reg <= wakeCnt_reg + 1'b1;
    end
  end

  assign ready = !asleep && !waking_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stopSeen <= 1'b0;
      startSeen <= 1'b0;
    end
    else
    begin
      stopSeen <= stopDet;
      startSeen <= startDet;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_ack_release;
    @(posedge clk) disable iff (!resetn)
      (state_reg == ST_ACK && sclRise) |=> (!sdaOe && asleep);
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released");

  property p_sleep_start;
    @(posedge clk) disable iff (!resetn)
      $rose(asleep) |-> $past(sclRise) && $past(state_reg == ST_ACK);
  endproperty
  a_sleep_start: assert property (p_sleep_start) else $error("bad sleep entry");

  property p_sleep_release;
    @(posedge clk) disable iff (!resetn)
      asleep |-> !sdaOe;
  endproperty
  a_sleep_release: assert property (p_sleep_release) else $error("drive in sleep");

  property p_stop_flag;
    @(posedge clk) disable iff (!resetn)
      (scl && $past(scl) && sda && !$past(sda)) |=> stopSeen;
  endproperty
  a_stop_flag: assert property (p_stop_flag) else $error("stop missed");

  // Cycles since a wake request while not ready; the recovery span is far too
  // long for a delay range, so a counter carries the bound instead
  logic [$clog2(WAKE_CYCLES_P+2)-1:0] wakeWatch_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wakeWatch_reg <= '0;
    else if (asleep && wakeReq)
      wakeWatch_reg <= ($bits(wakeWatch_reg))'(1);
    else if (wakeWatch_reg != '0 && !ready)
      wakeWatch_reg <= wakeWatch_reg + 1'b1;
    else
      wakeWatch_reg <= '0;
  end

  property p_wake_hold;
    @(posedge clk) disable iff (!resetn)
      (asleep && wakeReq) |=> !ready;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("ready before recovery");

  property p_wake_bound;
    @(posedge clk) disable iff (!resetn)
      wakeWatch_reg <= ($bits(wakeWatch_reg))'(WAKE_CYCLES_P + 1);
  endproperty
  a_wake_bound: assert property (p_wake_bound) else $error("wake too slow");

  c_ack: cover property (@(posedge clk) disable iff (!resetn) state_reg == ST_ACK);
  c_sleep: cover property (@(posedge clk) disable iff (!resetn) $rose(asleep));
  c_stop: cover property (@(posedge clk) disable iff (!resetn) asleep && stopDet);
  c_wake: cover property (@(posedge clk) disable iff (!resetn) $rose(ready));
endmodule // sleep_entry

/* sleep_entry_pkg.sv */
// Constants for the two-wire memory sleep-entry block.
// Assumes a 250 MHz system clock; bus pins arrive asynchronously.
package sleep_entry_pkg;
  localparam logic [7:0] SLEEP_FINAL_ADDR = 8'h86;
  localparam logic [3:0] ACK_EDGE = 4'h9;
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAKE_TIME_US = 400;
  // Longest time rounds down to whole cycles
  localparam int WAKE_CYCLES = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;
endpackage

/* pin_sync.sv */
// Two-flop synchroniser for the bus pins.
// Assumes the inputs are asynchronous to clk.
module pin_sync
  import sleep_entry_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclSync,
  output logic sdaSync
);
  logic [1:0] sclStage_reg;
  logic [1:0] sdaStage_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclStage_reg <= 2'h3;
      sdaStage_reg <= 2'h3;
    end
    else
    begin
      sclStage_reg <= {sclStage_reg[0], sclIn};
      sdaStage_reg <= {sdaStage_reg[0], sdaIn};
    end
  end

  assign sclSync = sclStage_reg[1];
  assign sdaSync = sdaStage_reg[1];
endmodule // pin_sync

/* i2c_ctrl_model.sv */
// Behavioural bus controller that sends bytes of the sleep sequence.
// Assumes the bench resolves the open-drain data wire with a pull-up.
module i2c_ctrl_model
(
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock idles high between frames; stops are never watched, so none aborts us
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic start_cond();
    sdaLow = 1'b1;
    #24;
    scl = 1'b0;
    #12;
  endtask
  // ----------------------------------------
  // Byte with acknowledge slot
  // ----------------------------------------
  task automatic send_byte(input logic [7:0] b, input logic hold, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaLow = ~b[i];
      #12;
      scl = 1'b1;
      #24;
      scl = 1'b0;
      #12;
    end
    sdaLow = 1'b0;
    #36;
    scl = 1'b1;
    ack = (sda === 1'b0);
    sdaLow = hold & ack;
    // Long high phase so the device release lands while clock is high
    #96;
    scl = 1'b0;
    #12;
    sdaLow = 1'b0;
    #12;
    scl = 1'b1;
    #24;
  endtask
endmodule // i2c_ctrl_model

/* sleep_entry_tb_top.sv */
// Self-checking bench for the sleep-entry block.
// Assumes a pull-up on the data wire and a controller model on the bus.
module sleep_entry_tb_top
  import sleep_entry_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WP = 20;
  logic clk, resetn, sleepArmed, wakeReq, scl, ctrlLow;
  logic sdaOut, sdaOe, asleep, ready, stopSeen, startSeen;
  wire logic sda = ~((sdaOe & ~sdaOut) | ctrlLow);
  int n_fail = 0, checks = 0, nStop = 0, nStart = 0;
  sleep_entry #(.WAKE_CYCLES_P(WP)) u_sleep_entry (.clk(clk), .resetn(resetn),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .sleepArmed(sleepArmed),
    .wakeReq(wakeReq), .asleep(asleep), .ready(ready), .stopSeen(stopSeen),
    .startSeen(startSeen));
  i2c_ctrl_model u_i2c_ctrl_model (.scl(scl), .sdaLow(ctrlLow), .sda(sda));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    nStop <= nStop + int'(stopSeen === 1'b1);
    nStart <= nStart + int'(startSeen === 1'b1);
  end
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp, input string msg);
    cmp_bit(got == exp, 1'b1, msg);
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_no_ack();
    logic ack;
    int s0;
    s0 = nStart;
    u_i2c_ctrl_model.start_cond();
    u_i2c_ctrl_model.send_byte(SLEEP_FINAL_ADDR, 1'b0, ack);
    cmp_bit(ack, 1'b0, "ack while not armed");
    @(posedge clk);
    #1 sleepArmed = 1'b1;
    u_i2c_ctrl_model.start_cond();
    u_i2c_ctrl_model.send_byte(SLEEP_FINAL_ADDR ^ 8'h01, 1'b0, ack);
    cmp_bit(ack, 1'b0, "ack on other byte");
    cmp_bit(asleep, 1'b0, "slept on other byte");
    cmp_cnt(nStart - s0, 2, "start count");
    $display("Test no_ack done");
  endtask
  task automatic t_sleep(input logic hold);
    logic ack;
    int s0;
    s0 = nStop;
    u_i2c_ctrl_model.start_cond();
    u_i2c_ctrl_model.send_byte(SLEEP_FINAL_ADDR, hold, ack);
    cmp_bit(ack, 1'b1, "final byte not acked");
    cmp_bit(asleep, 1'b1, "not asleep");
    cmp_bit(ready, 1'b0, "ready in sleep");
    cmp_bit(sdaOe, 1'b0, "data held in sleep");
    cmp_cnt(nStop - s0, hold ? 0 : 1, "stop count at entry");
    u_i2c_ctrl_model.start_cond();
    u_i2c_ctrl_model.send_byte(SLEEP_FINAL_ADDR, 1'b0, ack);
    cmp_bit(ack, 1'b0, "ack while asleep");
    $display("Test sleep hold=%0b done", hold);
  endtask
  task automatic t_wake();
    int n;
    @(posedge clk);
    #1 wakeReq = 1'b1;
    @(posedge clk);
    #1 wakeReq = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_bit(asleep, 1'b0, "still asleep");
    cmp_bit(n <= WP, 1'b1, "recovery too long");
    $display("Test wake done after %0d cycles", n);
  endtask
  initial
  begin
    sleepArmed = 1'b0;
    wakeReq = 1'b0;
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clk);
    // Keeps every bus change of the controller model off the sampling edge
    #1;
    cmp_bit(ready, 1'b1, "not ready after reset");
    t_no_ack();
    t_sleep(1'b0);
    t_wake();
    t_sleep(1'b1);
    t_wake();
    complete_run();
  end
  // Tests take a few microseconds; this bound only cuts a hang
  initial
  begin
    #50000;
    n_fail++;
    $display("Error %0t: watchdog expired", $time);
    complete_run();
  end
endmodule // sleep_entry_tb_top
